// ---- pwmd_top.sv ----
// 14-bit pulse-division pwm with axi4-lite register access
`default_nettype none
`include "pwmd_defines.svh"
module pwmd_top
  import pwmd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic        pwm_pin_out,
  output var  logic        pwm_pin_sel
);
  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // byte address of a register index
  function automatic logic [31:0] addr_of(input logic [15:0] idx);
    addr_of = {14'h0000, idx, 2'b00};
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a == addr_of(`PWMD_IDX_CTRL))  ||
             (a == addr_of(`PWMD_IDX_UPPER)) ||
             (a == addr_of(`PWMD_IDX_LOWER)) ||
             (a == addr_of(`PWMD_IDX_STATUS)) ||
             (a == addr_of(`PWMD_IDX_PMODE));
  endfunction

  // reset images as named vectors, so single fields can be picked out
  localparam logic [7:0] ctrl_rst  = `PWMD_CTRL_RESET;
  localparam logic [7:0] upper_rst = `PWMD_UPPER_RESET;

  // high units per period: value plus the fixed offset
  function automatic logic [13:0] high_units(input logic [13:0] v);
    high_units = v + `PWMD_HIGH_OFFSET;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  pwmd_wr_t    wr_req;
  logic        wr_fire;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] rd_word;
  logic        ctrl_sel_ff;
  logic [5:0]  upper_ff;
  logic [7:0]  lower_ff;
  logic [7:0]  pmode_ff;
  logic [13:0] pend_value_ff;
  logic        pend_ff;
  pwmd_cfg_t   active_ff;
  logic        div_ff;
  logic [7:0]  unit_cnt_ff;
  logic [5:0]  pulse_cnt_ff;
  logic        wave_ff;
  logic        bonus;
  logic        unit_tick;
  logic        pulse_end;
  logic        boundary;
  logic        full;
  logic        level;
  logic [13:0] nxt_value;
  logic [13:0] units;
  logic [13:0] nxt_units;
  logic        wr_ctrl;
  logic        wr_upper;
  logic        wr_lower;
  logic        wr_pmode;

  ////////////////////////////////////////////////////////////////////////
  // bus slave

  pwmd_axil_slave u_slave (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_req        (wr_req),
    .wr_fire       (wr_fire),
    .wr_hit        (wr_hit),
    .rd_hit        (rd_hit),
    .rd_word       (rd_word)
  );

  // write strobes; only byte lane 0 carries register data
  assign wr_hit   = mapped(wr_req.addr);
  assign rd_hit   = mapped(s_axi_araddr);
  assign wr_ctrl  = wr_fire && wr_req.strb &&
                    wr_req.addr == addr_of(`PWMD_IDX_CTRL);
  assign wr_upper = wr_fire && wr_req.strb &&
                    wr_req.addr == addr_of(`PWMD_IDX_UPPER);
  assign wr_lower = wr_fire && wr_req.strb &&
                    wr_req.addr == addr_of(`PWMD_IDX_LOWER);
  assign wr_pmode = wr_fire && wr_req.strb &&
                    wr_req.addr == addr_of(`PWMD_IDX_PMODE);

  // read mux: write-only registers hide their contents
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == addr_of(`PWMD_IDX_CTRL)) begin
      rd_word = `PWMD_READ_ONES;
    end else if (s_axi_araddr == addr_of(`PWMD_IDX_UPPER)) begin
      rd_word = `PWMD_READ_ONES;
    end else if (s_axi_araddr == addr_of(`PWMD_IDX_LOWER)) begin
      rd_word = `PWMD_READ_ONES;
    end else if (s_axi_araddr == addr_of(`PWMD_IDX_PMODE)) begin
      rd_word = {24'h000000, pmode_ff};
    end else if (s_axi_araddr == addr_of(`PWMD_IDX_STATUS)) begin
      rd_word = {15'h0000, wave_ff, pend_ff, active_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  // control: only the select bit is stored, the rest is constant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_sel_ff <= ctrl_rst[`PWMD_CTRL_SEL];
    end else if (wr_ctrl) begin
      ctrl_sel_ff <= wr_req.data[`PWMD_CTRL_SEL];
    end
  end

  // data bytes; upper keeps only its six width bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upper_ff <= upper_rst[5:0];
      lower_ff <= `PWMD_LOWER_RESET;
    end else begin
      if (wr_upper) begin
        upper_ff <= wr_req.data[5:0];
      end
      if (wr_lower) begin
        lower_ff <= wr_req.data;
      end
    end
  end

  // port mode register with the pin-select bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pmode_ff <= `PWMD_PMODE_RESET;
    end else if (wr_pmode) begin
      pmode_ff <= wr_req.data;
    end
  end

  // upper write latches the pair; a new latch beats the boundary clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_value_ff <= 14'h0000;
      pend_ff       <= 1'b0;
    end else if (wr_upper) begin
      pend_value_ff <= {wr_req.data[5:0], lower_ff};
      pend_ff       <= 1'b1;
    end else if (boundary) begin
      pend_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // waveform timing

  // one unit is half the input clock: 1 or 2 system clocks
  assign unit_tick = !active_ff.sel || div_ff;
  assign pulse_end = unit_tick && unit_cnt_ff == `PWMD_UNIT_LAST;
  assign boundary  = pulse_end && pulse_cnt_ff == `PWMD_PULSE_LAST;
  assign nxt_value = (boundary && pend_ff) ? pend_value_ff
                                           : active_ff.value;
  assign units     = high_units(active_ff.value);
  assign nxt_units = high_units(nxt_value);
  assign full      = active_ff.value >= `PWMD_FULL_MIN;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 1'b0;
    end else begin
      div_ff <= active_ff.sel && !div_ff;
    end
  end

  // 256 units per pulse, 64 pulses per period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unit_cnt_ff  <= 8'h00;
      pulse_cnt_ff <= 6'h00;
    end else if (unit_tick) begin
      unit_cnt_ff <= unit_cnt_ff + 8'h01;
      if (pulse_end) begin
        pulse_cnt_ff <= pulse_cnt_ff + 6'h01;
      end
    end
  end

  // settings change only between periods, never mid-period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_ff.sel   <= ctrl_rst[`PWMD_CTRL_SEL];
      active_ff.value <= {upper_rst[5:0], `PWMD_LOWER_RESET};
    end else if (boundary) begin
      active_ff.sel   <= ctrl_sel_ff;
      active_ff.value <= nxt_value;
    end
  end

  pwmd_spread u_spread (
    .aclk    (aclk),
    .aresetn (aresetn),
    .step    (pulse_end),
    .restart (boundary),
    .frac    (nxt_units[5:0]),
    .bonus   (bonus)
  );

  // base units from the upper bits, one more on bonus pulses
  assign level = full ||
                 ({1'b0, unit_cnt_ff} <
                  {1'b0, units[13:6]} + {8'h00, bonus});

  // output pin is registered; held low while the pin is not selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_ff     <= 1'b0;
      pwm_pin_out <= 1'b0;
      pwm_pin_sel <= 1'b0;
    end else begin
      wave_ff     <= level;
      pwm_pin_out <= pmode_ff[`PWMD_PMODE_PWM] && level;
      pwm_pin_sel <= pmode_ff[`PWMD_PMODE_PWM];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic [14:0] hi_cnt_ff;
  logic [6:0]  bonus_cnt_ff;

  // high units and bonus pulses counted over each period
  always_ff @(posedge aclk) begin
    if (!aresetn || boundary) begin
      hi_cnt_ff    <= 15'h0000;
      bonus_cnt_ff <= 7'h00;
    end else begin
      if (unit_tick && level) begin
        hi_cnt_ff <= hi_cnt_ff + 15'h0001;
      end
      if (pulse_end && bonus) begin
        bonus_cnt_ff <= bonus_cnt_ff + 7'h01;
      end
    end
  end

  chk_period_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (boundary && !full && $past(boundary, 1) == 1'b0 &&
     active_ff.value == $past(active_ff.value, 1))
    |-> (hi_cnt_ff + {14'h0000, level}) == {1'b0, units})
    else $error("high units per period differ from value plus 64");

  chk_even_spread: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (boundary && !full && $past(boundary, 1) == 1'b0 &&
     active_ff.value == $past(active_ff.value, 1))
    |-> (bonus_cnt_ff + {6'h00, bonus}) == {1'b0, units[5:0]})
    else $error("bonus pulses per period differ from spare units");

  chk_ctrl_reads: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready &&
     s_axi_araddr == addr_of(`PWMD_IDX_CTRL))
    |=> (s_axi_rvalid && s_axi_rdata == `PWMD_READ_ONES))
    else $error("control register did not read all ones");

  chk_data_reads: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready &&
     (s_axi_araddr == addr_of(`PWMD_IDX_UPPER) ||
      s_axi_araddr == addr_of(`PWMD_IDX_LOWER)))
    |=> (s_axi_rvalid && s_axi_rdata == `PWMD_READ_ONES))
    else $error("data register did not read all ones");

  chk_reset_values: assert property (
    @(posedge aclk)
    !aresetn |=> (ctrl_sel_ff == 1'b0 && upper_ff == 6'h00 &&
                  lower_ff == 8'h00 && active_ff.value == 14'h0000))
    else $error("registers not at reset values after reset");

  chk_upper_latch: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_upper |=> (pend_ff &&
      pend_value_ff == {$past(wr_req.data[5:0]), $past(lower_ff)}))
    else $error("upper write did not latch the value");

  chk_lower_alone: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_lower |=> (pend_value_ff == $past(pend_value_ff) &&
                  (!pend_ff || $past(pend_ff))))
    else $error("lower write alone latched a value");

  chk_full_high: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (full && !boundary) [*2] |-> wave_ff)
    else $error("output not high at full-scale value");

  chk_half_rate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (active_ff.sel && unit_tick && !boundary) |=> !unit_tick)
    else $error("div4 input advanced on consecutive clocks");

  chk_period_swap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !boundary |=> $stable(active_ff))
    else $error("settings changed inside a conversion period");

  chk_pin_select: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !pmode_ff[`PWMD_PMODE_PWM] |=> !pwm_pin_out)
    else $error("pin driven with pwm while not selected");

endmodule
`default_nettype wire

// ---- pwmd_defines.svh ----
// register map, reset values and field positions of the 14-bit pwm
// Behaviour
// - select bit picks input clock div2/div4
// - select bit is write-only, reads one
// - control bits 7..1 read one, ignore writes
// - control register resets to FE
// - value is upper[5:0] over lower[7:0]
// - high time is (value+64) half-periods
// - upper write latches value; lower alone doesn't
// - data registers read all ones
// - data registers reset to C000
// - period is 64 equal pulses
// - value 3FC0..3FFF gives constant high output
// - value zero gives 32 input-clock high periods
// - pin carries pwm only when selected
// - high time spread over pulses, less ripple
`ifndef PWMD_DEFINES_SVH
`define PWMD_DEFINES_SVH
`define PWMD_IDX_CTRL    16'hFFCC
`define PWMD_IDX_UPPER   16'hFFCD
`define PWMD_IDX_LOWER   16'hFFCE
`define PWMD_IDX_STATUS  16'hFFCF
`define PWMD_IDX_PMODE   16'hFFEC
`define PWMD_CTRL_RESET  8'hFE
`define PWMD_UPPER_RESET 8'hC0
`define PWMD_LOWER_RESET 8'h00
`define PWMD_PMODE_RESET 8'h00
`define PWMD_CTRL_SEL    0
`define PWMD_PMODE_PWM   0
`define PWMD_READ_ONES   32'h0000_00FF
`define PWMD_FULL_MIN    14'h3FC0
`define PWMD_HIGH_OFFSET 14'h0040
`define PWMD_UNIT_LAST   8'hFF
`define PWMD_PULSE_LAST  6'h3F
`define PWMD_RESP_OKAY   2'h0
`define PWMD_RESP_SLVERR 2'h2
`endif

// ---- pwmd_pkg.sv ----
// types shared by the pwm register slave and waveform logic
`default_nettype none
package pwmd_pkg;
  // one accepted register write
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
    logic        strb;
  } pwmd_wr_t;
  // waveform settings in use for one conversion period
  typedef struct packed {
    logic        sel;
    logic [13:0] value;
  } pwmd_cfg_t;
endpackage
`default_nettype wire

// ---- pwmd_spread.sv ----
// spreads the leftover high units evenly over the 64 pulses
`default_nettype none
module pwmd_spread
  import pwmd_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       step,
  input  wire logic       restart,
  input  wire logic [5:0] frac,
  output var  logic       bonus
);
  logic [5:0] acc_ff;
  logic [6:0] nxt_sum;

  // accumulator overflow marks a pulse that gets one extra unit
  always_comb begin
    nxt_sum = {1'b0, restart ? 6'h00 : acc_ff} + {1'b0, frac};
  end

  // 64 additions of frac give exactly frac carries per period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= 6'h00;
      bonus  <= 1'b0;
    end else if (step) begin
      acc_ff <= nxt_sum[5:0];
      bonus  <= nxt_sum[6];
    end
  end
endmodule
`default_nettype wire

// ---- pwmd_axil_slave.sv ----
// axi4-lite slave: one write and one read in flight at a time
`default_nettype none
module pwmd_axil_slave
  import pwmd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  pwmd_wr_t    wr_req,
  output var  logic        wr_fire,
  input  wire logic        wr_hit,
  input  wire logic        rd_hit,
  input  wire logic [31:0] rd_word
);
  logic fire;
  assign fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // address and data are taken in either order, then one fire pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PWMD_RESP_OKAY;
      wr_fire       <= 1'b0;
      wr_req        <= '0;
    end else begin
      wr_fire <= fire;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_req.addr   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_req.data  <= s_axi_wdata[7:0];
        wr_req.strb  <= s_axi_wstrb[0];
      end
      if (fire) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? `PWMD_RESP_OKAY : `PWMD_RESP_SLVERR;
      end else if (s_axi_bready && s_axi_bvalid) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data is sampled when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PWMD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? `PWMD_RESP_OKAY : `PWMD_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the 14-bit pwm register slave and waveform
`default_nettype none
`include "pwmd_defines.svh"
module tb_top
  import pwmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] a_ctrl  = {14'h0000, `PWMD_IDX_CTRL, 2'h0};
  localparam logic [31:0] a_upper = {14'h0000, `PWMD_IDX_UPPER, 2'h0};
  localparam logic [31:0] a_lower = {14'h0000, `PWMD_IDX_LOWER, 2'h0};
  localparam logic [31:0] a_stat  = {14'h0000, `PWMD_IDX_STATUS, 2'h0};
  localparam logic [31:0] a_pmode = {14'h0000, `PWMD_IDX_PMODE, 2'h0};
  localparam logic [31:0] a_none  = 32'h0003_FF40;
  localparam logic [31:0] ones    = 32'h0000_00FF;
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [31:0] s_axi_awaddr  = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [31:0] s_axi_araddr  = 32'h0000_0000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic        pwm_pin_out;
  logic        pwm_pin_sel;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          n_fail        = 0;
  int          n_tests       = 0;
  int          hi;
  int          rises;
  int          mn;
  int          mx;

  // 40 mhz system clock
  always #12.5 aclk = ~aclk;

  pwmd_top i_pwmd_top (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pwm_pin_out(pwm_pin_out),
    .pwm_pin_sel(pwm_pin_sel)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // write with address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    if (s_axi_bvalid !== 1'b1) n_fail++;
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    if (s_axi_rvalid !== 1'b1) n_fail++;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // lower byte first, then the upper byte that latches both
  task automatic set_val(input logic [13:0] v);
    axi_wr(a_lower, {24'h000000, v[7:0]});
    axi_wr(a_upper, {26'h0000000, v[13:8]});
  endtask

  // polls status until the latched value is active; bounded by reads
  task automatic wait_act(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      axi_rd(a_stat);
      n++;
    end while ((rd & 32'h0000_FFFF) !== exp && n < 12000);
    chk(rd & 32'h0000_FFFF, exp);
  endtask

  // counts high cycles, rises and complete high runs over a window
  task automatic meas(input int len);
    logic p;
    logic q;
    int   run;
    int   k;
    hi = 0;
    rises = 0;
    mn = 99999;
    mx = 0;
    run = 0;
    q = 1'b0;
    k = 0;
    while (pwm_pin_out !== 1'b0 && k < 1000) begin
      @(posedge aclk);
      k++;
    end
    repeat (len) begin
      @(posedge aclk);
      p = (pwm_pin_out === 1'b1);
      if (p) begin
        hi++;
        run++;
        if (!q) rises++;
      end else begin
        if (q && run < mn) mn = run;
        if (q && run > mx) mx = run;
        run = 0;
      end
      q = p;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    axi_rd(a_ctrl);
    chk(rd, ones);
    chk(rs, `PWMD_RESP_OKAY);
    axi_rd(a_upper);
    chk(rd, ones);
    axi_rd(a_lower);
    chk(rd, ones);
    axi_rd(a_stat);
    chk(rd & 32'h0000_FFFF, 32'h0000_0000);
  endtask

  // unmapped place refused; reserved control bits written, sel untouched
  task automatic t_bad;
    axi_wr(a_none, 32'h0000_0055);
    chk(rs, `PWMD_RESP_SLVERR);
    axi_rd(a_none);
    chk(rd, 32'h0000_0000);
    chk(rs, `PWMD_RESP_SLVERR);
    axi_wr(a_ctrl, 32'h0000_00FE);
    axi_rd(a_ctrl);
    chk(rd, ones);
  endtask

  task automatic t_pin;
    meas(600);
    chk(hi, 0);
    chk(pwm_pin_sel, 1'b0);
    axi_wr(a_pmode, 32'h0000_0001);
    chk(rs, `PWMD_RESP_OKAY);
    // a write with lane 0 off is answered but leaves the byte alone
    s_axi_wstrb <= 4'h0;
    axi_wr(a_pmode, 32'h0000_0000);
    chk(rs, `PWMD_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(a_pmode);
    chk(rd, 32'h0000_0001);
    chk(pwm_pin_sel, 1'b1);
  endtask

  // reset value zero: 64 units, one unit on each of 64 pulses
  task automatic t_zero;
    meas(16384);
    chk(hi, 64);
    chk(rises, 64);
    chk(mn, 1);
    chk(mx, 1);
  endtask

  task automatic t_full(input logic [13:0] v);
    set_val(v);
    wait_act({18'h00000, v});
    meas(2000);
    chk(hi, 2000);
  endtask

  // 0x1234 gives 0x1274 units: base 73, one more on 52 pulses
  task automatic t_value;
    set_val(14'h1234);
    axi_rd(a_stat);
    chk(rd & 32'h0000_FFFF, 32'h0000_BFFF);
    wait_act(32'h0000_1234);
    meas(16384);
    chk(hi, 4724);
    chk(rises, 64);
    chk(mn, 73);
    chk(mx, 74);
    axi_wr(a_lower, 32'h0000_0000);
    axi_rd(a_stat);
    chk(rd & 32'h0000_FFFF, 32'h0000_1234);
  endtask

  // divide by four doubles every unit
  task automatic t_div4;
    axi_wr(a_ctrl, 32'h0000_0001);
    axi_rd(a_ctrl);
    chk(rd, ones);
    set_val(14'h1234);
    wait_act(32'h0000_5234);
    meas(4000);
    chk(mn, 146);
    chk(mx, 148);
    axi_wr(a_ctrl, 32'h0000_0000);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_bad();
    t_pin();
    t_zero();
    t_full(14'h3FFF);
    t_value();
    t_full(14'h3FC0);
    t_div4();
    end_sim();
  end

  // watchdog sized above the longest expected run of period waits
  initial begin
    repeat (110000) @(posedge aclk);
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
